// ==== arfs_top.sv ====
// arfs_top: register side of a 10-bit converter: input select, result format, result bytes
// assumes an apb master on clk_in and a converter core on the same clock
// What this block does
// RQ1: single-ended result is unsigned 0x000..0x3FF
// RQ2: differential result is two's complement 0x200..0x1FF
// RQ3: result top bit in high byte shows sign
// RQ4: result readable once done flag sets
// RQ5: reference field 7:6 decodes four reference choices
// RQ6: reference change waits for running conversion end
// RQ7: bit 5 selects left or right alignment
// RQ8: alignment change shows immediately, even mid-conversion
// RQ9: input select resets zero, all bits read/write
// RQ10: alignment places bits across high and low bytes
// RQ11: channel field 4:0 change waits for conversion end
//
// The register addresses and register access over APB were decided locally.
`timescale 1ns/1ns
`default_nettype none
module arfs_top #(
    parameter int RES_W = 10 // converter result width
) (
    input wire logic clk_in, // 125 MHz system clock
    input wire logic rst_in, // synchronous, active high
    // apb slave
    input wire logic psel_in,
    input wire logic penable_in,
    input wire logic pwrite_in,
    input wire logic [11:0] paddr_in,
    input wire logic [31:0] pwdata_in,
    output logic [31:0] prdata_out,
    output logic pready_out,
    output logic pslverr_out,
    // converter core side, same clock
    input wire logic conv_start_in, // pulse: core begins sampling
    input wire logic conv_end_in, // pulse: core has a result
    input wire logic [RES_W-1:0] conv_code_in, // raw code from core
    input wire logic conv_diff_in, // core converted a differential pair
    output logic [1:0] ref_select_out, // reference in use by core
    output logic ref_internal_on_out, // internal reference enabled
    output logic [4:0] channel_select_out, // channel and gain in use
    output logic conversion_done_flag_out, // result valid
    output logic result_sign_bit_out // top bit of stored result
);
    // the byte views are written for exactly ten result bits
    if (RES_W != 10) begin : g_width_check
        $error("arfs_top serves a 10-bit result only");
    end

    logic [7:0] input_select_register; // software copy, read/write
    logic [1:0] ref_active; // reference held for the core
    logic [4:0] chan_active; // channel held for the core
    logic busy; // conversion running
    logic conversion_done_flag; // sticky done
    logic [RES_W-1:0] result; // stored result code
    logic result_diff; // stored result is signed
    logic [7:0] result_low_byte; // aligned low view
    logic [7:0] result_high_byte; // aligned high view

    // bus decode, access phase only
    wire access = psel_in & penable_in;
    wire wr = access & pwrite_in & pready_out; // write lands only at the ready edge
    wire hit_sel = paddr_in == arfs_pkg::OFF_INPUT_SELECT;
    wire hit_low = paddr_in == arfs_pkg::OFF_RESULT_LOW;
    wire hit_high = paddr_in == arfs_pkg::OFF_RESULT_HIGH;
    wire hit_stat = paddr_in == arfs_pkg::OFF_STATUS;
    wire hit_any = hit_sel | hit_low | hit_high | hit_stat;
    wire wr_sel = wr & hit_sel;
    // reading the high byte clears done; a new end the same cycle wins
    wire rd_high = access & ~pwrite_in & hit_high & pready_out;
    wire [7:0] next_select = pwdata_in[7:0];
    // reference and channel latch only while idle or at conversion end
    wire idle_load = ~busy | conv_end_in; // RQ6 RQ11
    wire [7:0] status = {5'h00, result_diff, busy, conversion_done_flag};
    wire [31:0] next_rdata = hit_sel ? {24'h000000, input_select_register} :
                             hit_low ? {24'h000000, result_low_byte} :
                             hit_high ? {24'h000000, result_high_byte} :
                             hit_stat ? {24'h000000, status} : 32'h00000000;

    // alignment view follows the live select bit, no register in between
    arfs_align #(.RES_W(RES_W)) u_align (
        .result_in(result),
        .left_align_in(input_select_register[arfs_pkg::LEFT_ALIGN_BIT]), // RQ8
        .low_out(result_low_byte),
        .high_out(result_high_byte)
    );

    // software register, every bit writable
    always_ff @(posedge clk_in) begin
        if (rst_in) begin
            input_select_register <= arfs_pkg::INPUT_SELECT_RESET; // RQ9
        end else if (wr_sel) begin
            input_select_register <= next_select; // RQ9
        end
    end

    // active selections seen by the core
    always_ff @(posedge clk_in) begin
        if (rst_in) begin
            ref_active <= arfs_pkg::REF_EXTERNAL_PIN;
            chan_active <= 5'h00;
        end else if (idle_load) begin
            ref_active <= input_select_register[arfs_pkg::REF_SEL_HI:arfs_pkg::REF_SEL_LO]; // RQ6
            chan_active <= input_select_register[arfs_pkg::CHAN_SEL_HI:arfs_pkg::CHAN_SEL_LO]; // RQ11
        end
    end

    // conversion tracking and result capture
    always_ff @(posedge clk_in) begin
        if (rst_in) begin
            busy <= 1'b0;
            conversion_done_flag <= 1'b0;
            result <= 10'h000;
            result_diff <= 1'b0;
        end else begin
            if (conv_start_in) begin
                busy <= 1'b1;
            end else if (conv_end_in) begin
                busy <= 1'b0;
            end
            if (conv_end_in) begin
                // core code is unsigned or two's complement; stored as is
                result <= conv_code_in; // RQ1 RQ2 RQ4
                result_diff <= conv_diff_in;
                conversion_done_flag <= 1'b1; // RQ4
            end else if (rd_high) begin
                conversion_done_flag <= 1'b0;
            end
        end
    end

    // outputs registered; reserved reference code keeps internal ref off
    always_ff @(posedge clk_in) begin
        if (rst_in) begin
            prdata_out <= 32'h00000000;
            pready_out <= 1'b0;
            pslverr_out <= 1'b0;
            ref_select_out <= arfs_pkg::REF_EXTERNAL_PIN;
            ref_internal_on_out <= 1'b0;
            channel_select_out <= 5'h00;
            conversion_done_flag_out <= 1'b0;
            result_sign_bit_out <= 1'b0;
        end else begin
            // one wait state: ready rises the cycle after access starts
            pready_out <= access & ~pready_out;
            pslverr_out <= access & ~pready_out & ~hit_any;
            prdata_out <= (access & ~pready_out & ~pwrite_in) ? next_rdata : 32'h00000000;
            ref_select_out <= ref_active; // RQ5
            ref_internal_on_out <= ref_active == arfs_pkg::REF_INTERNAL_256; // RQ5
            channel_select_out <= chan_active;
            conversion_done_flag_out <= conversion_done_flag;
            result_sign_bit_out <= result[RES_W-1]; // RQ3
        end
    end

    // reference held through a running conversion
    ref_hold_a: assert property (@(posedge clk_in) disable iff (rst_in) // RQ6
        busy && !conv_end_in |=> $stable(ref_active))
        else $error("reference changed mid conversion");
    // channel held through a running conversion
    chan_hold_a: assert property (@(posedge clk_in) disable iff (rst_in) // RQ11
        busy && !conv_end_in |=> $stable(chan_active))
        else $error("channel changed mid conversion");
    // done flag sets with the captured result
    done_set_a: assert property (@(posedge clk_in) disable iff (rst_in) // RQ4
        conv_end_in |=> conversion_done_flag && result == $past(conv_code_in))
        else $error("result not captured with done flag");
    // left view shows top eight bits high
    align_left_a: assert property (@(posedge clk_in) disable iff (rst_in) // RQ7
        input_select_register[5] |-> result_high_byte == result[9:2])
        else $error("left alignment wrong");
    // right view zero-fills the high byte
    align_right_a: assert property (@(posedge clk_in) disable iff (rst_in) // RQ10
        !input_select_register[5] |-> result_high_byte[7:2] == 6'h00
        && result_low_byte == result[7:0])
        else $error("right alignment wrong");
    // alignment write shows the next cycle regardless of busy
    align_now_a: assert property (@(posedge clk_in) disable iff (rst_in) // RQ8
        wr_sel |=> input_select_register[5] == $past(pwdata_in[5]))
        else $error("alignment not immediate");
    // sign pin follows stored top bit
    sign_bit_a: assert property (@(posedge clk_in) disable iff (rst_in) // RQ3
        1'b1 |=> result_sign_bit_out == $past(result[9]))
        else $error("sign bit wrong");
    // internal reference on only for code three
    ref_decode_a: assert property (@(posedge clk_in) disable iff (rst_in) // RQ5
        1'b1 |=> ref_internal_on_out == ($past(ref_active) == 2'h3))
        else $error("reference decode wrong");
    // whole select register written back
    sel_rw_a: assert property (@(posedge clk_in) disable iff (rst_in) // RQ9
        wr_sel |=> input_select_register == $past(pwdata_in[7:0]))
        else $error("select register write lost");
    // ready is a single-cycle pulse
    ready_pulse_a: assert property (@(posedge clk_in) disable iff (rst_in)
        pready_out |=> !pready_out)
        else $error("ready held too long");
    // every access phase is answered after one wait state
    ready_timing_a: assert property (@(posedge clk_in) disable iff (rst_in)
        psel_in && penable_in && !pready_out |=> pready_out)
        else $error("access not answered");
    // error response only alongside ready
    slverr_ready_a: assert property (@(posedge clk_in) disable iff (rst_in)
        pslverr_out |-> pready_out)
        else $error("error without ready");
    // read data idles at zero outside the ready cycle
    rdata_idle_a: assert property (@(posedge clk_in) disable iff (rst_in)
        !pready_out |-> prdata_out == 32'h00000000)
        else $error("read data not idle");
    // done clears after a high byte read unless a result lands
    done_clear_a: assert property (@(posedge clk_in) disable iff (rst_in) // RQ4
        rd_high && !conv_end_in |=> !conversion_done_flag)
        else $error("done flag not cleared");
    // pending reference taken up at conversion end
    ref_reload_a: assert property (@(posedge clk_in) disable iff (rst_in) // RQ6
        conv_end_in |=> ref_active ==
        $past(input_select_register[arfs_pkg::REF_SEL_HI:arfs_pkg::REF_SEL_LO]))
        else $error("reference not reloaded");
    // pending channel taken up at conversion end
    chan_reload_a: assert property (@(posedge clk_in) disable iff (rst_in) // RQ11
        conv_end_in |=> chan_active ==
        $past(input_select_register[arfs_pkg::CHAN_SEL_HI:arfs_pkg::CHAN_SEL_LO]))
        else $error("channel not reloaded");
    // start marks the converter busy
    busy_set_a: assert property (@(posedge clk_in) disable iff (rst_in)
        conv_start_in |=> busy)
        else $error("busy not set");
endmodule
`default_nettype wire

// ==== arfs_pkg.sv ====
// arfs_pkg: shared constants for the converter result format and reference select block
// assumes a 32-bit apb register bus, one aligned word per register
package arfs_pkg;
    // register byte offsets
    localparam logic [11:0] OFF_INPUT_SELECT = 12'h000; // input select register
    localparam logic [11:0] OFF_RESULT_LOW = 12'h004; // result low byte
    localparam logic [11:0] OFF_RESULT_HIGH = 12'h008; // result high byte
    localparam logic [11:0] OFF_STATUS = 12'h00C; // busy, done, differential
    // input select field layout
    localparam int REF_SEL_HI = 7;
    localparam int REF_SEL_LO = 6;
    localparam int LEFT_ALIGN_BIT = 5;
    localparam int CHAN_SEL_HI = 4;
    localparam int CHAN_SEL_LO = 0;
    localparam logic [7:0] INPUT_SELECT_RESET = 8'h00;
    // status register bit positions
    localparam int STAT_DONE_BIT = 0;
    localparam int STAT_BUSY_BIT = 1;
    localparam int STAT_DIFF_BIT = 2;
    // reference select codes
    localparam logic [1:0] REF_EXTERNAL_PIN = 2'h0;
    localparam logic [1:0] REF_ANALOG_SUPPLY = 2'h1;
    localparam logic [1:0] REF_RESERVED = 2'h2;
    localparam logic [1:0] REF_INTERNAL_256 = 2'h3;
    // result code limits
    localparam logic [9:0] SE_CODE_MIN = 10'h000;
    localparam logic [9:0] SE_CODE_MAX = 10'h3FF;
    localparam logic [9:0] DIFF_CODE_MOST_NEG = 10'h200;
    localparam logic [9:0] DIFF_CODE_MOST_POS = 10'h1FF;
endpackage

// ==== arfs_align.sv ====
// arfs_align: presents a stored 10-bit result as two bytes, left or right aligned
// assumes the caller registers the outputs if it needs them from flip-flops
`timescale 1ns/1ns
`default_nettype none
module arfs_align #(
    parameter int RES_W = 10 // result width
) (
    input wire logic [RES_W-1:0] result_in, // stored result
    input wire logic left_align_in, // one selects left alignment
    output logic [7:0] low_out, // low byte view
    output logic [7:0] high_out // high byte view
);
    // the slices below are fixed for ten result bits
    if (RES_W != 10) begin : g_width_check
        $error("arfs_align serves a 10-bit result only");
    end
    // left: bits 9..2 high, bits 1..0 in top of low; right: 7..0 low, 9..8 in bottom of high
    wire [7:0] left_low = {result_in[1:0], 6'h00}; // RQ10
    wire [7:0] left_high = result_in[9:2]; // RQ10
    wire [7:0] right_low = result_in[7:0]; // RQ10
    wire [7:0] right_high = {6'h00, result_in[9:8]}; // RQ10
    // pure combinational so a change of alignment shows at once
    assign low_out = left_align_in ? left_low : right_low; // RQ7
    assign high_out = left_align_in ? left_high : right_high; // RQ7
endmodule
`default_nettype wire

// ==== arfs_core_model.sv ====
// arfs_core_model: behavioural converter core on the far side of the result logic
// assumes the bench pulses go_in for one cycle per conversion
`timescale 1ns/1ns
`default_nettype none
module arfs_core_model (
    input wire logic clk_in,
    input wire logic rst_in,
    input wire logic go_in, // pulse: begin a conversion
    input wire logic [7:0] len_in, // cycles from start to end
    input wire logic [9:0] code_in, // code to hand over
    input wire logic diff_in, // code is differential
    output logic conv_start_out,
    output logic conv_end_out,
    output logic [9:0] code_out,
    output logic diff_out
);
    logic [7:0] cnt; // cycles left in the conversion
    // code lines toggle outside the end pulse so a stale code never looks valid
    always_ff @(posedge clk_in) begin
        conv_start_out <= 1'b0;
        conv_end_out <= 1'b0;
        code_out <= ~code_out;
        diff_out <= ~diff_out;
        if (rst_in) begin
            cnt <= 8'h00;
            code_out <= 10'h000;
            diff_out <= 1'b0;
        end else if (go_in) begin
            conv_start_out <= 1'b1;
            cnt <= len_in;
        end else if (cnt == 8'h01) begin
            conv_end_out <= 1'b1; // result valid in this cycle only
            code_out <= code_in;
            diff_out <= diff_in;
            cnt <= 8'h00;
        end else if (cnt != 8'h00) begin
            cnt <= cnt - 8'h01;
        end
    end
endmodule
`default_nettype wire

// ==== tb_adc_result_format_and_ref_select.sv ====
// tb_adc_result_format_and_ref_select: self-checking bench for arfs_top
// assumes arfs_pkg and arfs_core_model are compiled first
`timescale 1ns/1ns
`default_nettype none
module tb_adc_result_format_and_ref_select;
    typedef struct {logic [7:0] ctl; logic [9:0] code; logic dif; logic [7:0] lo, hi;} arfs_row_s;
    logic clk_in = 0, rst_in = 1, psel = 0, penable = 0, pwrite = 0, go = 0, dif = 0;
    logic [11:0] paddr = 12'h000;
    logic [31:0] pwdata = 32'h0, prdata, rd;
    logic pready, pslverr, err, c_start, c_end, c_diff, done, sign, ref_on;
    logic [9:0] code = 10'h000, c_code;
    logic [7:0] len = 8'h05;
    logic [1:0] ref_sel;
    logic [4:0] chan;
    int fail_count = 0, num_checks = 0;
    arfs_row_s rows [8];
    always #4 clk_in = ~clk_in;
    arfs_top dut (.clk_in(clk_in), .rst_in(rst_in), .psel_in(psel), .penable_in(penable),
        .pwrite_in(pwrite), .paddr_in(paddr), .pwdata_in(pwdata), .prdata_out(prdata),
        .pready_out(pready), .pslverr_out(pslverr), .conv_start_in(c_start),
        .conv_end_in(c_end), .conv_code_in(c_code), .conv_diff_in(c_diff),
        .ref_select_out(ref_sel), .ref_internal_on_out(ref_on), .channel_select_out(chan),
        .conversion_done_flag_out(done), .result_sign_bit_out(sign));
    arfs_core_model core (.clk_in(clk_in), .rst_in(rst_in), .go_in(go), .len_in(len),
        .code_in(code), .diff_in(dif), .conv_start_out(c_start), .conv_end_out(c_end),
        .code_out(c_code), .diff_out(c_diff));
    task automatic stop_test;
        if (fail_count == 0 && num_checks > 0)
            $display("*** PASS ***");
        else
            $display("*** FAIL ***");
        $finish;
    endtask
    // one compare for every result; x never matches
    task automatic check(input string what, input logic [31:0] exp, input logic [31:0] got);
        num_checks++;
        if (got !== exp) begin
            fail_count++;
            $display("mismatch %s expected %h seen %h", what, exp, got);
        end
    endtask
    // apb transfer: setup, then access held until pready at a rising edge
    task automatic apb(input int wr, input logic [11:0] a, input logic [31:0] wd);
        int n;
        n = 0;
        @(posedge clk_in);
        {psel, pwrite, paddr, pwdata} <= {1'b1, (wr != 0), a, wd};
        @(posedge clk_in);
        penable <= 1'b1;
        do begin @(posedge clk_in); n++; end while (pready !== 1'b1 && n < 20);
        if (n >= 20) fail_count++; // slave never answered
        rd = prdata;
        err = pslverr;
        {psel, penable} <= 2'b00;
    endtask
    task automatic start_conv(input logic [9:0] c, input logic d, input logic [7:0] l);
        @(posedge clk_in);
        {go, code, dif, len} <= {1'b1, c, d, l};
        @(posedge clk_in);
        go <= 1'b0;
    endtask
    task automatic wait_done;
        int n;
        for (n = 0; n < 60 && done !== 1'b1; n++) @(posedge clk_in);
    endtask
    initial begin
        // control byte, code, differential, expected low and high bytes
        rows = '{'{8'h29, 10'h270, 1'b1, 8'h00, 8'h9C}, '{8'h49, 10'h270, 1'b1, 8'h70, 8'h02},
            '{8'hB0, 10'h029, 1'b1, 8'h40, 8'h0A}, '{8'hD0, 10'h029, 1'b1, 8'h29, 8'h00},
            '{8'h1F, 10'h3FF, 1'b0, 8'hFF, 8'h03}, '{8'h60, 10'h000, 1'b0, 8'h00, 8'h00},
            '{8'h80, 10'h200, 1'b1, 8'h00, 8'h02}, '{8'hE0, 10'h1FF, 1'b1, 8'hC0, 8'h7F}};
        repeat (3) @(posedge clk_in);
        rst_in <= 1'b0;
        apb(0, arfs_pkg::OFF_INPUT_SELECT, 32'h0);
        check("select reset", 32'h0, rd);
        apb(1, arfs_pkg::OFF_INPUT_SELECT, 32'hFF);
        apb(0, arfs_pkg::OFF_INPUT_SELECT, 32'h0);
        check("select all bits", 32'hFF, rd);
        apb(1, 12'h010, 32'h5);
        check("unmapped error", 32'h1, {31'h0, err});
        foreach (rows[i]) begin
            apb(1, arfs_pkg::OFF_INPUT_SELECT, {24'h0, rows[i].ctl});
            start_conv(rows[i].code, rows[i].dif, 8'h05);
            wait_done;
            check("done flag", 32'h1, {31'h0, done});
            check("sign bit", {31'h0, rows[i].code[9]}, {31'h0, sign});
            check("reference", {30'h0, rows[i].ctl[7:6]}, {30'h0, ref_sel});
            check("internal on", {31'h0, &rows[i].ctl[7:6]}, {31'h0, ref_on});
            check("channel", {27'h0, rows[i].ctl[4:0]}, {27'h0, chan});
            apb(0, arfs_pkg::OFF_RESULT_LOW, 32'h0);
            check("low byte", {24'h0, rows[i].lo}, rd);
            apb(0, arfs_pkg::OFF_STATUS, 32'h0);
            check("status", {29'h0, rows[i].dif, 2'b01}, rd);
            apb(0, arfs_pkg::OFF_RESULT_HIGH, 32'h0);
            check("high byte", {24'h0, rows[i].hi}, rd);
        end
        // selection written mid-conversion waits; alignment shows at once
        start_conv(10'h155, 1'b0, 8'h1E);
        apb(1, arfs_pkg::OFF_INPUT_SELECT, 32'h45);
        apb(0, arfs_pkg::OFF_RESULT_LOW, 32'h0);
        check("realigned low", 32'hFF, rd);
        check("old reference", 32'h3, {30'h0, ref_sel});
        check("old channel", 32'h0, {27'h0, chan});
        apb(0, arfs_pkg::OFF_STATUS, 32'h0);
        check("busy status", 32'h6, rd);
        wait_done;
        repeat (2) @(posedge clk_in);
        check("new reference", 32'h1, {30'h0, ref_sel});
        check("new channel", 32'h5, {27'h0, chan});
        apb(0, arfs_pkg::OFF_RESULT_LOW, 32'h0);
        check("single ended low", 32'h55, rd);
        apb(0, arfs_pkg::OFF_RESULT_HIGH, 32'h0);
        check("single ended high", 32'h01, rd);
        repeat (2) @(posedge clk_in);
        check("done cleared", 32'h0, {31'h0, done});
        // mid-run reset returns the registers to their reset state
        rst_in <= 1'b1;
        repeat (3) @(posedge clk_in);
        rst_in <= 1'b0;
        apb(0, arfs_pkg::OFF_INPUT_SELECT, 32'h0);
        check("select after reset", 32'h0, rd);
        check("done after reset", 32'h0, {31'h0, done});
        check("reference after reset", 32'h0, {30'h0, ref_sel});
        stop_test;
    end
    // watchdog: the full sequence needs well under this span
    initial begin
        #200000;
        fail_count++;
        stop_test;
    end
endmodule
`default_nettype wire
